// >>> inc/dwt_pkg.sv
// constants and state type for the warning threshold register bank
package dwt_pkg;
  // serial slave address on the 2-wire bus
  localparam logic [6:0] DEV_ADDR = 7'h51;
  // byte addresses of the threshold bytes
  localparam logic [7:0] OFS_VOLT_LOW_HI = 8'h0e;
  localparam logic [7:0] OFS_VOLT_LOW_LO = 8'h0f;
  localparam logic [7:0] OFS_BIAS_HIGH_HI = 8'h14;
  localparam logic [7:0] OFS_BIAS_HIGH_LO = 8'h15;
  localparam logic [7:0] OFS_BIAS_LOW_HI = 8'h16;
  localparam logic [7:0] OFS_BIAS_LOW_LO = 8'h17;
  localparam logic [7:0] OFS_TXPWR_HIGH_HI = 8'h1c;
  localparam logic [7:0] OFS_TXPWR_HIGH_LO = 8'h1d;
  // reset value of every threshold byte
  localparam logic [7:0] THRESH_RST = 8'h00;
  // answer for an unmapped byte address
  localparam logic [7:0] UNMAPPED_RD = 8'h00;
  // scaling of threshold counts, informational only
  localparam real VOLT_HI_LSB_MV = 25.6;
  localparam real TXPWR_HI_LSB_UW = 25.6;
  localparam real TXPWR_LO_LSB_UW = 0.1;
  // positions of the warning bits
  localparam int WARN_VOLT_LOW = 0;
  localparam int WARN_BIAS_HIGH = 1;
  localparam int WARN_BIAS_LOW = 2;
  localparam int WARN_TXPWR_HIGH = 3;
  localparam int WARN_W = 4;
  // bits per serial byte
  localparam logic [3:0] BYTE_BITS = 4'h8;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_RACK} dwt_state_t;
  typedef enum logic [1:0] {KIND_ADDR, KIND_PTR, KIND_DATA} dwt_kind_t;

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_prev;
    logic sda_prev;
    dwt_state_t state;
    dwt_kind_t kind;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic rd;
    logic hnack;
    logic sda_oe;
    logic sda_o;
    logic [7:0] vl_hi;
    logic [7:0] vl_lo;
    logic [7:0] bh_hi;
    logic [7:0] bh_lo;
    logic [7:0] bl_hi;
    logic [7:0] bl_lo;
    logic [7:0] th_hi;
    logic [7:0] th_lo;
    logic [WARN_W-1:0] warn;
  } dwt_regs_t;
endpackage

// >>> verilog/dwt_threshold_bank.sv
// warning threshold register bank with 2-wire serial slave and comparators
//
// Functional notes
// (R1) the voltage-low warning sets when the supply high byte is below its threshold high byte.
// (R2) the bias-high warning sets when the bias high byte is above its threshold high byte.
// (R3) the bias-low warning sets when the bias high byte is below its threshold high byte.
// (R4) the tx-power-high warning sets when the tx power high byte exceeds its threshold high byte.
// (R5) only threshold high bytes take part in comparisons; low bytes never affect a flag.
// (R6) every threshold byte comes out of reset as zero.
// (R7) one count of the tx-power-high threshold high byte is 25.6 microwatts.
// (R8) the tx-power threshold pair is unsigned, with the low byte worth 0.1 microwatt per count.
// (R9) each high byte and the low byte after it form one 16-bit value, high byte first.
// (R10) thresholds are compared against raw measurements with no calibration.
// (R11) the host should write zero to every low threshold byte.
// (R12) all threshold bytes answer at 7-bit serial slave address 1010001.
// (R13) one count of the voltage threshold high byte is 25.6 millivolts.
// (R14) each warning is re-evaluated when a new measurement of its parameter is stored.
`timescale 1ns/1ns
module dwt_threshold_bank
  import dwt_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [7:0] supply_meas_hi_in,
  input wire logic supply_meas_store_in,
  input wire logic [7:0] bias_meas_hi_in,
  input wire logic bias_meas_store_in,
  input wire logic [7:0] txpwr_meas_hi_in,
  input wire logic txpwr_meas_store_in,
  output logic [WARN_W-1:0] warning_flag_out
);

  dwt_regs_t r;
  dwt_regs_t r_nxt;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] rd_val;

  // read mux; unmapped addresses answer a fixed byte
  function automatic logic [7:0] rd_byte(input logic [7:0] a, input dwt_regs_t s);
    logic [7:0] v;
    v = UNMAPPED_RD;
    if (a == OFS_VOLT_LOW_HI) begin
      v = s.vl_hi;
    end else if (a == OFS_VOLT_LOW_LO) begin
      v = s.vl_lo;
    end else if (a == OFS_BIAS_HIGH_HI) begin
      v = s.bh_hi;
    end else if (a == OFS_BIAS_HIGH_LO) begin
      v = s.bh_lo;
    end else if (a == OFS_BIAS_LOW_HI) begin
      v = s.bl_hi;
    end else if (a == OFS_BIAS_LOW_LO) begin
      v = s.bl_lo;
    end else if (a == OFS_TXPWR_HIGH_HI) begin
      v = s.th_hi;
    end else if (a == OFS_TXPWR_HIGH_LO) begin
      v = s.th_lo;
    end
    return v;
  endfunction

  // edges only look at the second synchroniser stage
  assign scl_rise = r.scl_sync[1] & ~r.scl_prev;
  assign scl_fall = ~r.scl_sync[1] & r.scl_prev;
  assign bus_start = r.scl_sync[1] & r.scl_prev & r.sda_prev & ~r.sda_sync[1];
  assign bus_stop = r.scl_sync[1] & r.scl_prev & ~r.sda_prev & r.sda_sync[1];
  // byte the pointer addresses, loaded into the shifter at the start of each read byte
  assign rd_val = rd_byte(r.ptr, r);

  always_comb begin
    r_nxt = r;
    r_nxt.scl_sync = {r.scl_sync[0], scl_in};
    r_nxt.sda_sync = {r.sda_sync[0], sda_in};
    r_nxt.scl_prev = r.scl_sync[1];
    r_nxt.sda_prev = r.sda_sync[1];
    r_nxt.sda_o = 1'b0;

    if (bus_start) begin
      // a repeated start keeps the byte pointer for random reads
      r_nxt.state = ST_RX;
      r_nxt.kind = KIND_ADDR;
      r_nxt.cnt = 4'h0;
      r_nxt.sda_oe = 1'b0;
    end else if (bus_stop) begin
      r_nxt.state = ST_IDLE;
      r_nxt.sda_oe = 1'b0;
    end else begin
      case (r.state)
        ST_RX: begin
          if (scl_rise) begin
            r_nxt.shift = {r.shift[6:0], r.sda_sync[1]};
            r_nxt.cnt = r.cnt + 4'h1;
          end else if (scl_fall && r.cnt == BYTE_BITS) begin
            r_nxt.cnt = 4'h0;
            if (r.kind == KIND_ADDR) begin
              if (r.shift[7:1] == DEV_ADDR) begin // [R12]
                r_nxt.rd = r.shift[0];
                r_nxt.sda_oe = 1'b1;
                r_nxt.state = ST_ACK;
              end else begin
                r_nxt.state = ST_IDLE;
              end
            end else if (r.kind == KIND_PTR) begin
              r_nxt.ptr = r.shift;
              r_nxt.sda_oe = 1'b1;
              r_nxt.state = ST_ACK;
            end else begin
              // writes to unmapped bytes are acked and dropped
              if (r.ptr == OFS_VOLT_LOW_HI) begin
                r_nxt.vl_hi = r.shift;
              end else if (r.ptr == OFS_VOLT_LOW_LO) begin
                r_nxt.vl_lo = r.shift;
              end else if (r.ptr == OFS_BIAS_HIGH_HI) begin
                r_nxt.bh_hi = r.shift;
              end else if (r.ptr == OFS_BIAS_HIGH_LO) begin
                r_nxt.bh_lo = r.shift;
              end else if (r.ptr == OFS_BIAS_LOW_HI) begin
                r_nxt.bl_hi = r.shift;
              end else if (r.ptr == OFS_BIAS_LOW_LO) begin
                r_nxt.bl_lo = r.shift;
              end else if (r.ptr == OFS_TXPWR_HIGH_HI) begin
                r_nxt.th_hi = r.shift; // [R7]
              end else if (r.ptr == OFS_TXPWR_HIGH_LO) begin
                r_nxt.th_lo = r.shift; // [R8]
              end
              // pointer steps from a high byte onto its low byte
              r_nxt.ptr = r.ptr + 8'h01; // [R9]
              r_nxt.sda_oe = 1'b1;
              r_nxt.state = ST_ACK;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            r_nxt.cnt = 4'h0;
            if (r.kind == KIND_ADDR && r.rd) begin
              r_nxt.shift = rd_val;
              r_nxt.ptr = r.ptr + 8'h01; // [R9]
              r_nxt.sda_oe = ~rd_val[7];
              r_nxt.state = ST_TX;
            end else begin
              r_nxt.sda_oe = 1'b0;
              r_nxt.kind = (r.kind == KIND_ADDR) ? KIND_PTR : KIND_DATA;
              r_nxt.state = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            r_nxt.cnt = r.cnt + 4'h1;
          end else if (scl_fall) begin
            if (r.cnt == BYTE_BITS) begin
              r_nxt.sda_oe = 1'b0;
              r_nxt.state = ST_RACK;
            end else begin
              r_nxt.shift = {r.shift[6:0], 1'b0};
              r_nxt.sda_oe = ~r.shift[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            r_nxt.hnack = r.sda_sync[1];
          end else if (scl_fall) begin
            r_nxt.cnt = 4'h0;
            if (r.hnack) begin
              // host ended the read; wait for stop or start
              r_nxt.state = ST_IDLE;
            end else begin
              r_nxt.shift = rd_val;
              r_nxt.ptr = r.ptr + 8'h01;
              r_nxt.sda_oe = ~rd_val[7];
              r_nxt.state = ST_TX;
            end
          end
        end
        default: begin
          r_nxt.sda_oe = 1'b0;
        end
      endcase
    end

    // raw high bytes only; low threshold bytes never enter these compares
    if (supply_meas_store_in) begin
      r_nxt.warn[WARN_VOLT_LOW] = supply_meas_hi_in < r.vl_hi; // [R1] [R5] [R10] [R13] [R14]
    end
    if (bias_meas_store_in) begin
      r_nxt.warn[WARN_BIAS_HIGH] = bias_meas_hi_in > r.bh_hi; // [R2] [R5] [R10] [R14]
      r_nxt.warn[WARN_BIAS_LOW] = bias_meas_hi_in < r.bl_hi; // [R3] [R5] [R10] [R14]
    end
    if (txpwr_meas_store_in) begin
      r_nxt.warn[WARN_TXPWR_HIGH] = txpwr_meas_hi_in > r.th_hi; // [R4] [R5] [R10] [R14]
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      r <= '0;
      // bus lines idle high, so no false start right after reset
      r.scl_sync <= 2'h3;
      r.sda_sync <= 2'h3;
      r.scl_prev <= 1'b1;
      r.sda_prev <= 1'b1;
      r.vl_hi <= THRESH_RST; // [R6]
      r.vl_lo <= THRESH_RST; // [R6]
      r.bh_hi <= THRESH_RST; // [R6]
      r.bh_lo <= THRESH_RST; // [R6]
      r.bl_hi <= THRESH_RST; // [R6]
      r.bl_lo <= THRESH_RST; // [R6]
      r.th_hi <= THRESH_RST; // [R6]
      r.th_lo <= THRESH_RST; // [R6]
    end else begin
      r <= r_nxt;
    end
  end

  assign sda_out = r.sda_o;
  assign sda_oe_out = r.sda_oe;
  assign warning_flag_out = r.warn;

endmodule

// >>> tb/dwt_checker.sv
// port assertions for the warning threshold bank
`timescale 1ns/1ns
module dwt_checker
  import dwt_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_oe_out,
  input wire logic [7:0] supply_meas_hi_in,
  input wire logic supply_meas_store_in,
  input wire logic [7:0] bias_meas_hi_in,
  input wire logic bias_meas_store_in,
  input wire logic [7:0] txpwr_meas_hi_in,
  input wire logic txpwr_meas_store_in,
  input wire logic [WARN_W-1:0] warning_flag_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // extreme readings can never pass a strict compare, whatever the threshold
  property p_v_top;
    supply_meas_store_in && supply_meas_hi_in == 8'hff |=> !warning_flag_out[0];
  endproperty
  a_v_top: assert property (p_v_top) else $error("volt low set at top reading");
  property p_bh_zero;
    bias_meas_store_in && bias_meas_hi_in == 8'h00 |-> ##1 !warning_flag_out[1];
  endproperty
  a_bh_zero: assert property (p_bh_zero) else $error("bias high set at zero reading");
  property p_bl_top;
    bias_meas_store_in && bias_meas_hi_in == 8'hff |=> !warning_flag_out[2];
  endproperty
  a_bl_top: assert property (p_bl_top) else $error("bias low set at top reading");
  property p_tx_zero;
    txpwr_meas_store_in && txpwr_meas_hi_in == 8'h00 |=> !warning_flag_out[3];
  endproperty
  a_tx_zero: assert property (p_tx_zero) else $error("tx high set at zero reading");
  property p_v_hold;
    !supply_meas_store_in |=> $stable(warning_flag_out[0]);
  endproperty
  a_v_hold: assert property (p_v_hold) else $error("volt flag moved without store");
  property p_b_hold;
    !bias_meas_store_in |-> ##1 $stable(warning_flag_out[2:1]);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bias flags moved without store");
  property p_tx_hold;
    !txpwr_meas_store_in |=> $stable(warning_flag_out[3]);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx flag moved without store");
  property p_oe_scl;
    $changed(sda_oe_out) |-> !scl_in;
  endproperty
  a_oe_scl: assert property (p_oe_scl) else $error("data line moved while clock high");
  c_volt: cover property (warning_flag_out[0]);
  c_both_high: cover property (warning_flag_out[1] && warning_flag_out[3]);
  c_drive: cover property ($rose(sda_oe_out));
endmodule
bind dwt_threshold_bank dwt_checker chk_i (.clk_in, .rst_in, .scl_in, .sda_oe_out,
  .supply_meas_hi_in, .supply_meas_store_in, .bias_meas_hi_in, .bias_meas_store_in,
  .txpwr_meas_hi_in, .txpwr_meas_store_in, .warning_flag_out);

// >>> tb/dwt_host_model.sv
// host controller model on the 2-wire serial bus
`timescale 1ns/1ns
module dwt_host_model
  import dwt_pkg::*;
(
  input wire logic clk_in,
  input wire logic sda_oe_in,
  output logic scl_out,
  output logic sda_out
);
  logic drv = 1'b1;
  int hp = 10;
  initial scl_out = 1'b1;
  // open drain with pull-up: high unless someone pulls it low
  assign sda_out = drv & ~sda_oe_in;
  task automatic hw(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // data moves one cycle after the clock falls so it is never seen as start or stop
  task automatic bitx(input logic b, output logic got);
    hw(1);
    drv = b;
    hw(hp);
    scl_out = 1'b1;
    hw(hp / 2);
    got = sda_out;
    hw(hp - hp / 2);
    scl_out = 1'b0;
  endtask
  task automatic start();
    hw(1);
    drv = 1'b1;
    hw(hp);
    scl_out = 1'b1;
    hw(hp);
    drv = 1'b0;
    hw(hp);
    scl_out = 1'b0;
  endtask
  task automatic stop();
    hw(1);
    drv = 1'b0;
    hw(hp);
    scl_out = 1'b1;
    hw(hp);
    drv = 1'b1;
    hw(hp);
  endtask
  task automatic byte_x(input logic [7:0] tx, input logic ackb, output logic [7:0] rx,
    output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bitx(tx[i], g);
      rx[i] = g;
    end
    bitx(ackb, g);
    ack = ~g;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] dat,
    output logic ok);
    logic [7:0] r;
    logic a0, a1, a2;
    start();
    byte_x({dev, 1'b0}, 1'b1, r, a0);
    byte_x(ofs, 1'b1, r, a1);
    byte_x(dat, 1'b1, r, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  task automatic rd(input logic [7:0] ofs, output logic [7:0] dat);
    logic [7:0] r;
    logic a;
    start();
    byte_x({DEV_ADDR, 1'b0}, 1'b1, r, a);
    byte_x(ofs, 1'b1, r, a);
    start();
    byte_x({DEV_ADDR, 1'b1}, 1'b1, r, a);
    byte_x(8'hff, 1'b1, dat, a);
    stop();
  endtask
endmodule

// >>> tb/dwt_threshold_bank_tb_top.sv
// self-checking bench for the warning threshold bank
`timescale 1ns/1ns
module dwt_threshold_bank_tb_top;
  import dwt_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic scl, sda, sda_o, sda_oe, ok;
  logic [2:0] ss = 3'h0;
  logic [7:0] m = 8'h00;
  logic [7:0] d;
  logic [3:0] e;
  logic [WARN_W-1:0] wf;
  int n_mismatch = 0;
  int compares = 0;
  logic [7:0] ofs [8] = '{OFS_VOLT_LOW_HI, OFS_VOLT_LOW_LO, OFS_BIAS_HIGH_HI, OFS_BIAS_HIGH_LO,
    OFS_BIAS_LOW_HI, OFS_BIAS_LOW_LO, OFS_TXPWR_HIGH_HI, OFS_TXPWR_HIGH_LO};
  logic [7:0] thr [4] = '{8'h80, 8'h80, 8'h40, 8'h80};
  logic [7:0] mv [8] = '{8'h00, 8'h3f, 8'h40, 8'h41, 8'h7f, 8'h80, 8'h81, 8'hff};
  always #5 clk = ~clk;
  dwt_threshold_bank uut (.clk_in(clk), .rst_in(rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .supply_meas_hi_in(m), .supply_meas_store_in(ss[0]),
    .bias_meas_hi_in(m), .bias_meas_store_in(ss[1]), .txpwr_meas_hi_in(m),
    .txpwr_meas_store_in(ss[2]), .warning_flag_out(wf));
  dwt_host_model host (.clk_in(clk), .sda_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic store(input logic [2:0] which, input logic [7:0] v);
    m = v;
    ss = which;
    @(posedge clk);
    #1 ss = 3'h0;
    @(posedge clk);
    #1;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      host.rd(ofs[i], d);
      chk(d, THRESH_RST);
      host.wr(DEV_ADDR, ofs[i], 8'ha0 + 8'(i), ok);
      chk({7'h0, ok}, 8'h01);
    end
    $display("reset values and writes done");
    host.hp = 20;
    for (int i = 0; i < 8; i++) begin
      host.rd(ofs[i], d);
      chk(d, 8'ha0 + 8'(i));
    end
    host.hp = 10;
    host.wr(7'h50, ofs[0], 8'h5a, ok);
    chk({7'h0, ok}, 8'h00);
    host.rd(ofs[0], d);
    chk(d, 8'ha0);
    host.rd(8'h20, d);
    chk(d, UNMAPPED_RD);
    $display("readback and addressing done");
    // low bytes keep nonzero values so a 16-bit compare would show up
    for (int i = 0; i < 4; i++) host.wr(DEV_ADDR, ofs[2 * i], thr[i], ok);
    foreach (mv[k]) begin
      store(3'h7, mv[k]);
      e = {mv[k] > thr[3], mv[k] < thr[2], mv[k] > thr[1], mv[k] < thr[0]};
      chk({4'h0, wf}, {4'h0, e});
    end
    $display("comparisons done");
    host.wr(DEV_ADDR, OFS_BIAS_HIGH_HI, 8'hff, ok);
    chk({4'h0, wf}, 8'h0a);
    store(3'h1, 8'h00);
    chk({4'h0, wf}, 8'h0b);
    store(3'h2, 8'hff);
    chk({4'h0, wf}, 8'h09);
    $display("re-evaluation done");
    // low bytes zeroed as the host is expected to; flags still follow the high bytes only
    for (int i = 0; i < 4; i++) host.wr(DEV_ADDR, ofs[2 * i + 1], 8'h00, ok);
    host.rd(ofs[3], d);
    chk(d, 8'h00);
    store(3'h7, 8'h80);
    chk({4'h0, wf}, 8'h00);
    chk({7'h0, sda_o}, 8'h00);
    $display("low byte zeroing done");
    report_and_stop();
  end
  initial begin
    #600000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
